// File: rtl/sdrc_regs.vh
/*
  Register offsets, field positions, reset values and rate tables of
  the converter control register bank. Assumes it is included by the
  register bank module only; holds definitions and nothing else.
*/
`ifndef SDRC_REGS_VH
`define SDRC_REGS_VH

// Register offsets in the 4-bit command address space
`define SDRC_ADDR_RES_HIGH 4'h0
`define SDRC_ADDR_RES_MID 4'h1
`define SDRC_ADDR_RES_LOW 4'h2
`define SDRC_ADDR_CTRL1 4'h3
`define SDRC_ADDR_CTRL2 4'h4
`define SDRC_ADDR_OFS_LOW 4'h8
`define SDRC_ADDR_OFS_MID 4'h9
`define SDRC_ADDR_OFS_HIGH 4'ha
`define SDRC_ADDR_GAIN_LOW 4'hb
`define SDRC_ADDR_GAIN_MID 4'hc
`define SDRC_ADDR_GAIN_HIGH 4'hd

// Command byte high nibbles
`define SDRC_CMD_READ 4'h4
`define SDRC_CMD_WRITE 4'h5

// Reset value of every register
`define SDRC_RST_BYTE 8'h00
`define SDRC_RST_WORD 24'h000000

// Writable bits; unassigned bits read as zero
`define SDRC_CTRL1_MASK 8'hfb
`define SDRC_CTRL2_MASK 8'h7f

// First control register fields
`define SDRC_GAIN_MSB 7
`define SDRC_GAIN_LSB 5
`define SDRC_OFS_EN_BIT 4
`define SDRC_GAIN_EN_BIT 3
`define SDRC_CHAN_HI_BIT 1
`define SDRC_CHAN_LO_BIT 0

// Second control register fields
`define SDRC_OVL_DIS_BIT 6
`define SDRC_OVR_DIS_BIT 5
`define SDRC_DIV_MSB 4
`define SDRC_DIV_LSB 3
`define SDRC_OSR_MSB 2
`define SDRC_OSR_LSB 0

// Oversampling ratio at code 000; each code step halves it
`define SDRC_OSR_BASE 12'h800
`define SDRC_OSR_LAST_CODE 3'h6

// Modulator clock divide ratio at code 00; each code step doubles it
`define SDRC_DIV_BASE 8'h10

// Gain coefficient scaling: 400000h means unity
`define SDRC_GAIN_SHIFT 22

// Result limits with and without the halved output range
`define SDRC_POS_FULL 24'h7fffff
`define SDRC_NEG_FULL 24'h800000
`define SDRC_POS_HALF 24'h3fffff
`define SDRC_NEG_HALF 24'hc00000

`endif

// File: rtl/sdrc_reg_bank.v
/*
  Control and status register bank of a 24-bit sigma-delta converter.
  Holds the result bytes, both control registers and the offset and
  gain calibration words; decodes register read and write command
  bytes; corrects and limits filter results; divides the device clock
  down to the modulator clock; counts the oversampling ratio.
  Assumes the command bytes come from a serial shifter on mclk_i,
  filter results come on mclk_i, and the overload comparator is
  asynchronous to mclk_i.
*/
// Function
// - Result bytes at 00h-02h, MSB first
// - Result bytes ignore writes; others read/write
// - Reset clears every register to 00h
// - Gain code bits 7-5 select 2^n
// - Bit 4 enables offset correction
// - Bit 3 enables gain correction
// - Bits 1-0 select input channel 0-3
// - Control write restarts modulator, filter; done high
// - Second control bit 6 disables overload detection
// - Second control bit 5 disables overrange detection
// - Bits 4-3 divide clock 16/32/64/128
// - Bits 2-0 set ratio 2048 down to 32
// - Offset word at 08h-0Ah, LSB first
// - Gain word at 0Bh-0Dh, LSB first
// - Read command 0100 rrrr returns register
// - Write command 0101 rrrr then data byte
// - Overrange disable halves output code range
`timescale 1ns/10ps
`include "sdrc_regs.vh"

module sdrc_reg_bank (
  // Clock, reset and clock enable
  input wire mclk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Command byte port from the serial shifter
  input wire cmd_valid_i,
  input wire [7:0] cmd_byte_i,
  output wire cmd_ready_o,
  output reg rd_valid_o,
  output reg [7:0] rd_data_o,
  // Raw filter result
  input wire res_valid_i,
  input wire [23:0] res_raw_i,
  // Analog overload comparator, asynchronous
  input wire overload_raw_i,
  // Converter control outputs
  output reg [2:0] amp_gain_code_o,
  output reg [7:0] amp_gain_o,
  output reg [1:0] channel_select_o,
  output reg mod_clk_o,
  output reg [11:0] osr_ratio_o,
  output reg decim_tick_o,
  output reg filter_reset_o,
  // Status outputs
  output reg conversion_done_n_o,
  output reg overload_o,
  output reg overrange_o
);

  // Register storage
  reg [7:0] first_control_reg_q;
  reg [7:0] second_control_reg_q;
  reg [23:0] offset_correction_value_q;
  reg [23:0] full_scale_coefficient_q;
  reg [23:0] result_q;
  // Command decoder state, one-hot
  localparam [1:0] ST_CMD = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] wr_addr_q;
  // Modulator clock divider and decimation counter
  reg [6:0] div_cnt_q;
  reg [11:0] osr_cnt_q;
  // Overload synchroniser and filtered level
  reg [2:0] ovl_sync_q;

  // Decoded fields
  wire offset_correct_enable;
  wire gain_correct_enable;
  wire analog_overload_disable;
  wire digital_overrange_disable;
  wire [1:0] modulator_clock_divider;
  wire [2:0] oversampling_ratio_code;
  wire [2:0] osr_code_eff;
  wire [7:0] div_ratio;
  wire [11:0] osr_ratio;
  assign offset_correct_enable = first_control_reg_q[`SDRC_OFS_EN_BIT];
  assign gain_correct_enable = first_control_reg_q[`SDRC_GAIN_EN_BIT];
  assign analog_overload_disable = second_control_reg_q[`SDRC_OVL_DIS_BIT];
  assign digital_overrange_disable = second_control_reg_q[`SDRC_OVR_DIS_BIT];
  assign modulator_clock_divider = second_control_reg_q[`SDRC_DIV_MSB:`SDRC_DIV_LSB];
  assign oversampling_ratio_code = second_control_reg_q[`SDRC_OSR_MSB:`SDRC_OSR_LSB];
  // Reserved code falls back to the fastest defined setting, 32
  assign osr_code_eff = (oversampling_ratio_code > `SDRC_OSR_LAST_CODE) ?
                        `SDRC_OSR_LAST_CODE : oversampling_ratio_code;
  assign div_ratio = `SDRC_DIV_BASE << modulator_clock_divider;
  assign osr_ratio = `SDRC_OSR_BASE >> osr_code_eff;

  // Command handshake: decoder never stalls
  assign cmd_ready_o = 1'b1;

  // Byte accepted this cycle
  wire cmd_take;
  assign cmd_take = ce_i & cmd_valid_i;
  // Write data byte lands this cycle
  wire wr_fire;
  assign wr_fire = cmd_take & (state_q == ST_DATA);
  // Any write to either control register restarts conversion
  wire ctrl_write;
  assign ctrl_write = wr_fire & ((wr_addr_q == `SDRC_ADDR_CTRL1) |
                                 (wr_addr_q == `SDRC_ADDR_CTRL2));
  // Read command decoded this cycle
  wire rd_fire;
  assign rd_fire = cmd_take & (state_q == ST_CMD) &
                   (cmd_byte_i[7:4] == `SDRC_CMD_READ);

  // Next state of the command decoder
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_CMD: begin
        // Only a write command waits for a data byte
        if (cmd_take && cmd_byte_i[7:4] == `SDRC_CMD_WRITE) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (cmd_take) begin
          state_d = ST_CMD;
        end
      end
      default: begin
        state_d = ST_CMD;
      end
    endcase
  end

  // Read-back multiplexer
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    case (cmd_byte_i[3:0])
      `SDRC_ADDR_RES_HIGH: rd_mux = result_q[23:16];
      `SDRC_ADDR_RES_MID: rd_mux = result_q[15:8];
      `SDRC_ADDR_RES_LOW: rd_mux = result_q[7:0];
      `SDRC_ADDR_CTRL1: rd_mux = first_control_reg_q;
      `SDRC_ADDR_CTRL2: rd_mux = second_control_reg_q;
      `SDRC_ADDR_OFS_LOW: rd_mux = offset_correction_value_q[7:0];
      `SDRC_ADDR_OFS_MID: rd_mux = offset_correction_value_q[15:8];
      `SDRC_ADDR_OFS_HIGH: rd_mux = offset_correction_value_q[23:16];
      `SDRC_ADDR_GAIN_LOW: rd_mux = full_scale_coefficient_q[7:0];
      `SDRC_ADDR_GAIN_MID: rd_mux = full_scale_coefficient_q[15:8];
      `SDRC_ADDR_GAIN_HIGH: rd_mux = full_scale_coefficient_q[23:16];
      // Unmapped addresses read as zero
      default: rd_mux = 8'h00;
    endcase
  end

  // Command decoder, read answer and register writes
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_CMD;
      wr_addr_q <= 4'h0;
      rd_valid_o <= 1'b0;
      rd_data_o <= `SDRC_RST_BYTE;
      first_control_reg_q <= `SDRC_RST_BYTE;
      second_control_reg_q <= `SDRC_RST_BYTE;
      offset_correction_value_q <= `SDRC_RST_WORD;
      full_scale_coefficient_q <= `SDRC_RST_WORD;
    end else if (ce_i) begin
      state_q <= state_d;
      // Read answer stands for one cycle
      rd_valid_o <= rd_fire;
      if (rd_fire) begin
        rd_data_o <= rd_mux;
      end
      if (cmd_take && state_q == ST_CMD) begin
        wr_addr_q <= cmd_byte_i[3:0];
      end
      // Result bytes have no write path; they fall to the default
      if (wr_fire) begin
        case (wr_addr_q)
          `SDRC_ADDR_CTRL1: first_control_reg_q <= cmd_byte_i & `SDRC_CTRL1_MASK;
          `SDRC_ADDR_CTRL2: second_control_reg_q <= cmd_byte_i & `SDRC_CTRL2_MASK;
          `SDRC_ADDR_OFS_LOW: offset_correction_value_q[7:0] <= cmd_byte_i;
          `SDRC_ADDR_OFS_MID: offset_correction_value_q[15:8] <= cmd_byte_i;
          `SDRC_ADDR_OFS_HIGH: offset_correction_value_q[23:16] <= cmd_byte_i;
          `SDRC_ADDR_GAIN_LOW: full_scale_coefficient_q[7:0] <= cmd_byte_i;
          `SDRC_ADDR_GAIN_MID: full_scale_coefficient_q[15:8] <= cmd_byte_i;
          `SDRC_ADDR_GAIN_HIGH: full_scale_coefficient_q[23:16] <= cmd_byte_i;
          // Result bytes and unmapped addresses ignore writes
          default: begin
          end
        endcase
      end
    end
  end

  // Result correction path, combinational
  reg signed [25:0] ofs_sum;
  reg signed [49:0] gain_prod;
  reg signed [25:0] corr;
  reg signed [25:0] lim_hi;
  reg signed [25:0] lim_lo;
  reg [23:0] res_d;
  reg ovr_d;
  always @* begin
    ofs_sum = 26'sd0;
    gain_prod = 50'sd0;
    corr = 26'sd0;
    lim_hi = 26'sd0;
    lim_lo = 26'sd0;
    res_d = 24'h000000;
    ovr_d = 1'b0;
    // Offset word is two's complement, added when enabled
    ofs_sum = {{2{res_raw_i[23]}}, res_raw_i};
    if (offset_correct_enable) begin
      ofs_sum = ofs_sum + {{2{offset_correction_value_q[23]}},
                           offset_correction_value_q};
    end
    // Gain word is positive; 400000h is unity
    corr = ofs_sum;
    if (gain_correct_enable) begin
      gain_prod = ofs_sum * $signed({2'b00, full_scale_coefficient_q});
      corr = gain_prod[`SDRC_GAIN_SHIFT+25:`SDRC_GAIN_SHIFT];
      // A coefficient above two can push the scaled code past 26 bits;
      // pin it at the rail so the limiter still clips on the right side
      if (gain_prod[49:47] != {3{gain_prod[49]}}) begin
        corr = {gain_prod[49], {25{~gain_prod[49]}}};
      end
    end
    // Halved range shifts the code right by one bit
    if (digital_overrange_disable) begin
      corr = corr >>> 1;
      lim_hi = {2'b00, `SDRC_POS_HALF};
      lim_lo = {2'b11, `SDRC_NEG_HALF};
    end else begin
      lim_hi = {2'b00, `SDRC_POS_FULL};
      lim_lo = {2'b11, `SDRC_NEG_FULL};
    end
    // Clipping always keeps the code inside the 24-bit range
    if (corr > lim_hi) begin
      res_d = lim_hi[23:0];
      ovr_d = 1'b1;
    end else if (corr < lim_lo) begin
      res_d = lim_lo[23:0];
      ovr_d = 1'b1;
    end else begin
      res_d = corr[23:0];
    end
  end

  // Result capture and conversion-done flag
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_q <= `SDRC_RST_WORD;
      conversion_done_n_o <= 1'b1;
      overrange_o <= 1'b0;
    end else if (ce_i) begin
      if (ctrl_write) begin
        // Restart discards any result still in flight
        conversion_done_n_o <= 1'b1;
      end else if (res_valid_i) begin
        result_q <= res_d;
        conversion_done_n_o <= 1'b0;
        // Flag is suppressed while detection is disabled
        overrange_o <= ovr_d & ~digital_overrange_disable;
      end else if (rd_fire && cmd_byte_i[3:0] == `SDRC_ADDR_RES_LOW) begin
        // Reading the last result byte ends the ready period
        conversion_done_n_o <= 1'b1;
      end
      // Disabling detection drops a flag left over from an earlier result
      if (digital_overrange_disable) begin
        overrange_o <= 1'b0;
      end
    end
  end

  // Modulator clock divider and decimation counter
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_q <= 7'h00;
      osr_cnt_q <= 12'h000;
      mod_clk_o <= 1'b0;
      decim_tick_o <= 1'b0;
      filter_reset_o <= 1'b0;
    end else if (ce_i) begin
      // Restart pulse stands for one cycle
      filter_reset_o <= ctrl_write;
      decim_tick_o <= 1'b0;
      if (ctrl_write) begin
        // Clean restart of both counters
        div_cnt_q <= 7'h00;
        osr_cnt_q <= 12'h000;
        mod_clk_o <= 1'b0;
      end else if (div_cnt_q == div_ratio[7:1] - 7'h01) begin
        // Half period done: toggle, count modulator cycles on rise
        div_cnt_q <= 7'h00;
        mod_clk_o <= ~mod_clk_o;
        if (!mod_clk_o) begin
          if (osr_cnt_q == osr_ratio - 12'h001) begin
            osr_cnt_q <= 12'h000;
            decim_tick_o <= 1'b1;
          end else begin
            osr_cnt_q <= osr_cnt_q + 12'h001;
          end
        end
      end else begin
        div_cnt_q <= div_cnt_q + 7'h01;
      end
    end
  end

  // Overload level: three stages, change taken when last two agree
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovl_sync_q <= 3'b000;
      overload_o <= 1'b0;
    end else if (ce_i) begin
      ovl_sync_q <= {ovl_sync_q[1:0], overload_raw_i};
      if (analog_overload_disable) begin
        overload_o <= 1'b0;
      end else if (ovl_sync_q[1] == ovl_sync_q[2]) begin
        overload_o <= ovl_sync_q[2];
      end
    end
  end

  // Settings driven to the analog front end from flops
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      amp_gain_code_o <= 3'h0;
      amp_gain_o <= 8'h01;
      channel_select_o <= 2'h0;
      osr_ratio_o <= `SDRC_OSR_BASE;
    end else if (ce_i) begin
      amp_gain_code_o <= first_control_reg_q[`SDRC_GAIN_MSB:`SDRC_GAIN_LSB];
      amp_gain_o <= 8'h01 << first_control_reg_q[`SDRC_GAIN_MSB:`SDRC_GAIN_LSB];
      channel_select_o <= {first_control_reg_q[`SDRC_CHAN_HI_BIT],
                           first_control_reg_q[`SDRC_CHAN_LO_BIT]};
      osr_ratio_o <= osr_ratio;
    end
  end

endmodule // sdrc_reg_bank

// File: verif/sdrc_reg_bank_checker.sv
/*
  Port checker for the converter register bank.
  Assumes one clock, an active-low asynchronous reset and the bind below.
*/
`timescale 1ns/10ps
module sdrc_reg_bank_checker (
  // Clock and reset
  input wire mclk_i,
  input wire rst_b_i,
  // Inputs watched
  input wire ce_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_byte_i,
  input wire res_valid_i,
  // Outputs watched
  input wire rd_valid_o,
  input wire [2:0] amp_gain_code_o,
  input wire [7:0] amp_gain_o,
  input wire [1:0] channel_select_o,
  input wire [11:0] osr_ratio_o,
  input wire filter_reset_o,
  input wire conversion_done_n_o,
  input wire overload_o,
  input wire overrange_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Shadow of the decoder: a write byte makes the next byte data
  reg data_q;
  reg [3:0] addr_q;
  reg [7:0] c1_q;
  reg [7:0] c2_q;
  wire take = ce_i && cmd_valid_i;
  wire rd_cmd = take && !data_q && cmd_byte_i[7:4] == 4'h4;
  wire ctl_wr = take && data_q && (addr_q == 4'h3 || addr_q == 4'h4);
  // Mirror of both control registers, unassigned bits kept zero
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_q <= 1'b0;
      addr_q <= 4'h0;
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else if (take) begin
      data_q <= !data_q && cmd_byte_i[7:4] == 4'h5;
      if (!data_q) addr_q <= cmd_byte_i[3:0];
      if (ctl_wr && addr_q == 4'h3) c1_q <= cmd_byte_i & 8'hfb;
      if (ctl_wr && addr_q == 4'h4) c2_q <= cmd_byte_i & 8'h7f;
    end
  end

  a_read_answer: assert property (rd_cmd |=> rd_valid_o)
    else $error("read command without answer");
  a_read_cause: assert property (rd_valid_o |-> $past(rd_cmd))
    else $error("answer without read command");
  a_ctrl_restart: assert property (ctl_wr |=> filter_reset_o && conversion_done_n_o)
    else $error("control write did not restart");
  a_restart_cause: assert property (filter_reset_o |-> $past(ctl_wr))
    else $error("restart without control write");
  a_gain_power: assert property (amp_gain_o == (8'h01 << amp_gain_code_o))
    else $error("gain not a power of two of code");
  a_ctrl1_fields: assert property ($stable(c1_q) |-> amp_gain_code_o == c1_q[7:5]
    && channel_select_o == c1_q[1:0])
    else $error("gain or channel field mismatch");
  a_osr_field: assert property ($stable(c2_q) |-> osr_ratio_o ==
    (12'h800 >> ((c2_q[2:0] == 3'h7) ? 3'h6 : c2_q[2:0])))
    else $error("ratio field mismatch");
  a_done_result: assert property (ce_i && res_valid_i && !ctl_wr |=> !conversion_done_n_o)
    else $error("done not low after result");
  a_ovl_gate: assert property (c2_q[6] && $past(c2_q[6]) |-> !overload_o)
    else $error("overload flagged while disabled");
  a_ovr_gate: assert property (c2_q[5] && $past(c2_q[5]) |-> !overrange_o)
    else $error("overrange flagged while disabled");

  // Main scenarios reached
  c_ctl_wr: cover property (ctl_wr);
  c_read: cover property (rd_valid_o);
  c_result: cover property (ce_i && res_valid_i);
  c_overload: cover property (overload_o);
endmodule // sdrc_reg_bank_checker

bind sdrc_reg_bank sdrc_reg_bank_checker sdrc_reg_bank_checker_i (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
  .cmd_byte_i(cmd_byte_i), .res_valid_i(res_valid_i), .rd_valid_o(rd_valid_o),
  .amp_gain_code_o(amp_gain_code_o), .amp_gain_o(amp_gain_o),
  .channel_select_o(channel_select_o), .osr_ratio_o(osr_ratio_o),
  .filter_reset_o(filter_reset_o), .conversion_done_n_o(conversion_done_n_o),
  .overload_o(overload_o), .overrange_o(overrange_o));

// File: verif/sdrc_host_model.sv
/*
  Host model sending register read and write command bytes.
  Assumes the bank takes one byte per strobe at a rising clock edge.
*/
`timescale 1ns/10ps
module sdrc_host_model (
  // Clock
  input wire mclk_i,
  // Byte strobe and byte to the bank
  output reg valid_o,
  output reg [7:0] byte_o
);
  initial begin
    valid_o = 1'b0;
    byte_o = 8'ha5;
  end
  // One byte, held over the taking edge
  task send(input [7:0] b);
    begin
      @(posedge mclk_i); #1;
      valid_o = 1'b1;
      byte_o = b;
      @(posedge mclk_i); #1;
      valid_o = 1'b0;
      // Released line shows the inverse, never a stale copy
      byte_o = ~b;
    end
  endtask
  // Read command: address in the low nibble
  task rd(input [3:0] a);
    send({4'h4, a});
  endtask
  // Write command, then the data byte
  task wr(input [3:0] a, input [7:0] d);
    begin
      send({4'h5, a});
      send(d);
    end
  endtask
endmodule // sdrc_host_model

// File: verif/tb_sigma_delta_adc_control_registers.sv
/*
  Self-checking bench for the register bank; reads queue expectations.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_sigma_delta_adc_control_registers;
  reg mclk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg res_valid_i = 1'b0;
  reg [23:0] res_raw_i = 24'h000000;
  reg ovl_raw = 1'b0;
  wire cmd_valid, rd_valid, mod_clk, done_n, ovl, ovr, tick, rdy;
  wire [7:0] cmd_byte, rd_data, gain;
  wire [11:0] osr;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i, n;
  integer seed = 32'he8ae;
  reg exp_ovr;
  reg [7:0] e, d [0:15];
  reg [23:0] r;
  time t0;
  reg [7:0] q[$];

  always #12.5 mclk_i = ~mclk_i;
  sdrc_host_model sdrc_host_model_i (.mclk_i(mclk_i), .valid_o(cmd_valid), .byte_o(cmd_byte));
  sdrc_reg_bank sdrc_reg_bank_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte), .cmd_ready_o(rdy), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .res_valid_i(res_valid_i), .res_raw_i(res_raw_i),
    .overload_raw_i(ovl_raw), .amp_gain_code_o(), .amp_gain_o(gain), .channel_select_o(),
    .mod_clk_o(mod_clk), .osr_ratio_o(osr), .decim_tick_o(tick), .filter_reset_o(),
    .conversion_done_n_o(done_n), .overload_o(ovl), .overrange_o(ovr));

  // Verdict and end of run
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard; the full run needs well under this
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  // Answer watcher: oldest note against each read answer
  always @(posedge mclk_i) if (rd_valid === 1'b1) begin
    if (q.size() == 0) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, rd_valid, 1'b0);
    end else begin
      e = q.pop_front();
      `CHK(rd_data, e)
    end
  end
  // Read with a noted expectation
  task rdx(input [3:0] a, input [7:0] x);
    begin
      q.push_back(x);
      sdrc_host_model_i.rd(a);
    end
  endtask
  // Writable bits per address; result and unmapped places give zero
  function [7:0] msk(input [3:0] a);
    msk = (a == 4'h3) ? 8'hfb : (a == 4'h4) ? 8'h7f : (a >= 4'h8 && a <= 4'hd) ? 8'hff : 8'h00;
  endfunction
  // Corrected, scaled and clipped code; unity gain is 400000h
  function [23:0] code(input [23:0] raw, input [7:0] c1, input [7:0] c2, input [23:0] o,
      input [23:0] g);
    reg signed [63:0] v, hi;
    begin
      v = $signed(raw);
      if (c1[4]) v = v + $signed(o);
      if (c1[3]) v = (v * $signed({40'h0, g})) >>> 22;
      if (c2[5]) v = v >>> 1;
      hi = c2[5] ? 64'sh3fffff : 64'sh7fffff;
      exp_ovr = (v > hi || v < -hi - 1) && !c2[5];
      if (v > hi) v = hi;
      if (v < -hi - 1) v = -hi - 1;
      code = v[23:0];
    end
  endfunction
  // Calibrate, post one result, restart, read the three bytes
  task res(input [23:0] raw, input [7:0] c1, input [7:0] c2, input [23:0] o, input [23:0] g);
    begin
      for (i = 0; i < 3; i++) sdrc_host_model_i.wr(8 + i, o[8*i +: 8]);
      for (i = 0; i < 3; i++) sdrc_host_model_i.wr(11 + i, g[8*i +: 8]);
      sdrc_host_model_i.wr(3, c1);
      sdrc_host_model_i.wr(4, c2);
      r = code(raw, c1, c2, o, g);
      res_valid_i = 1'b1;
      res_raw_i = raw;
      @(posedge mclk_i); #1;
      res_valid_i = 1'b0;
      res_raw_i = ~raw;
      `CHK(done_n, 1'b0)
      `CHK(ovr, exp_ovr)
      sdrc_host_model_i.wr(3, c1);
      `CHK(done_n, 1'b1)
      rdx(0, r[23:16]);
      rdx(1, r[15:8]);
      rdx(2, r[7:0]);
      $display("test result %h done", raw);
    end
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    `CHK(rdy, 1'b1)
    // Everything reads zero after reset
    for (n = 0; n < 16; n++) rdx(n, 8'h00);
    $display("test reset done");
    // Random data everywhere, back through the access masks
    for (n = 0; n < 16; n++) begin
      d[n] = $random(seed);
      sdrc_host_model_i.wr(n, d[n]);
    end
    for (n = 0; n < 16; n++) rdx(n, d[n] & msk(n));
    $display("test access done");
    // Mid-run reset clears what the access test left; last answer lands first
    repeat (2) @(posedge mclk_i);
    #1 rst_b_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    for (n = 0; n < 16; n++) rdx(n, 8'h00);
    $display("test mid reset done");
    // Every gain and ratio code, reserved ratio included
    for (n = 0; n < 8; n++) begin
      sdrc_host_model_i.wr(3, {n[2:0], 5'h00});
      sdrc_host_model_i.wr(4, {5'h00, n[2:0]});
      repeat (3) @(posedge mclk_i);
      `CHK(gain, 8'h01 << n)
      `CHK(osr, 12'h800 >> ((n == 7) ? 6 : n))
    end
    $display("test codes done");
    // Modulator clock period per divider code
    for (n = 0; n < 4; n++) begin
      sdrc_host_model_i.wr(4, {3'h0, n[1:0], 3'h0});
      @(posedge mod_clk);
      t0 = $time;
      @(posedge mod_clk);
      `CHK(int'(($time - t0) / 25), 16 << n)
    end
    $display("test divider done");
    // Output sample tick: ratio 32 at divide-by-16 gives 512 clocks
    sdrc_host_model_i.wr(4, 8'h06);
    @(posedge tick);
    t0 = $time;
    @(posedge tick);
    `CHK(int'(($time - t0) / 25), 512)
    $display("test decimation done");
    res($random(seed), 8'h00, 8'h00, 24'h0, 24'h0);
    res($random(seed), 8'h10, 8'h00, 24'h000123, 24'h0);
    res($random(seed), 8'h08, 8'h00, 24'h0, 24'h200000);
    // Large coefficient drives the scaled code past the working range
    res(24'h7fff00, 8'h18, 8'h00, 24'h3fff00, 24'hfffff0);
    res(24'h7ffff0, 8'h10, 8'h00, 24'h000100, 24'h0);
    res(24'h7ffff0, 8'h10, 8'h20, 24'h000100, 24'h0);
    res(24'h800000, 8'h00, 8'h20, 24'h0, 24'h0);
    // Overload seen when enabled, gated when disabled
    sdrc_host_model_i.wr(4, 8'h00);
    ovl_raw = 1'b1;
    repeat (8) @(posedge mclk_i);
    `CHK(ovl, 1'b1)
    sdrc_host_model_i.wr(4, 8'h40);
    repeat (3) @(posedge mclk_i);
    `CHK(ovl, 1'b0)
    #1 ovl_raw = 1'b0;
    $display("test overload done");
    repeat (5) @(posedge mclk_i);
    `CHK(q.size(), 0)
    report_and_stop;
  end
endmodule // tb_sigma_delta_adc_control_registers
